/* File: rtl/ccpr_pkg.sv */
package ccpr_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ       = 25_000_000;
  localparam int          RAMP_MS      = 80;
  localparam longint      RAMP_CYC_L   = (64'(RAMP_MS) * CLK_HZ) / 1000;
  localparam int          RAMP_CYCLES  = int'(RAMP_CYC_L);
  localparam int          HOST_QTR_CYC = 4;

  // ----------------------------------------------------------------
  // Link addressing
  // ----------------------------------------------------------------
  localparam logic [6:0]  SPI_CHIP_ADDR = 7'h4F;
  localparam logic [4:0]  I2C_ADDR_HI   = 5'h13;
  localparam int          PTR_STEP_BIT  = 7;

  // ----------------------------------------------------------------
  // Device register map
  // ----------------------------------------------------------------
  localparam logic [6:0]  REG_PWR       = 7'h02;
  localparam logic [7:0]  PWR_RST       = 8'h81;
  localparam int          PDN_BIT       = 0;
  localparam logic [6:0]  REG_ALERT_CFG = 7'h1F;
  localparam logic [6:0]  REG_IRQ_STAT  = 7'h20;
  localparam logic [6:0]  REG_IRQ_MASK  = 7'h21;
  localparam logic [6:0]  REG_TRIG_HI   = 7'h22;
  localparam logic [6:0]  REG_TRIG_LO   = 7'h23;

  typedef enum logic [1:0] {
    ALERT_LOW  = 2'h0,
    ALERT_HIGH = 2'h1,
    ALERT_OD   = 2'h2
  } ccpr_alert_t;

  typedef enum logic [2:0] {
    D_IDLE   = 3'h0,
    D_ADDR   = 3'h1,
    D_PTR    = 3'h3,
    D_WDATA  = 3'h2,
    D_RDATA  = 3'h6,
    D_IGNORE = 3'h7
  } ccpr_dst_t;

  // ----------------------------------------------------------------
  // Host controller map
  // ----------------------------------------------------------------
  localparam logic [2:0]  HA_CTRL  = 3'h0;
  localparam logic [2:0]  HA_PTR   = 3'h1;
  localparam logic [2:0]  HA_WDATA = 3'h2;
  localparam logic [2:0]  HA_RDATA = 3'h3;
  localparam logic [2:0]  HA_STAT  = 3'h4;
  localparam logic [2:0]  HA_PIN   = 3'h5;
  localparam int          CTRL_GO = 0;
  localparam int          CTRL_RD = 1;
  localparam int          CTRL_PO = 2;
  localparam int          PIN_RST_N  = 0;
  localparam int          PIN_I2C    = 1;
  localparam int          PIN_STRAP0 = 2;
  localparam int          PIN_STRAP1 = 3;

  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_START = 3'h1,
    H_BIT   = 3'h3,
    H_STOP  = 3'h2,
    H_GAP   = 3'h6
  } ccpr_hst_t;

endpackage : ccpr_pkg

/* File: rtl/ccpr_if.sv */
`timescale 1ns/1ps
interface ccpr_if;
  logic control_bit_clock;
  logic rst_pin_n;
  logic addr_strap_0_select;
  logic ad1;
  logic host_din_o;
  logic host_din_oe_n;
  logic dev_sda_oe_n;
  logic control_serial_out_o;
  logic control_serial_out_oe_n;
  logic alert_o;
  logic alert_oe_n;
  logic data_line;
  logic control_serial_out_line;
  logic alert_line;

  // Undriven lines read high, as with external pull-ups
  assign data_line  = (host_din_oe_n | host_din_o) & dev_sda_oe_n;
  assign control_serial_out_line = control_serial_out_oe_n ? 1'b1 : control_serial_out_o;
  assign alert_line = alert_oe_n ? 1'b1 : alert_o;

  modport dev (
    input  control_bit_clock, rst_pin_n, addr_strap_0_select, ad1, data_line,
    output dev_sda_oe_n, control_serial_out_o, control_serial_out_oe_n, alert_o, alert_oe_n
  );
  modport host (
    output control_bit_clock, rst_pin_n, addr_strap_0_select, ad1, host_din_o, host_din_oe_n,
    input  data_line, control_serial_out_line, alert_line
  );
endinterface : ccpr_if

/* File: rtl/ccpr_sync.sv */
`timescale 1ns/1ps
module ccpr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : ccpr_sync

/* File: rtl/ccpr_device.sv */
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - Falling select after reset chooses SPI, else I2C
// - SPI samples input rising, drives output falling
// - Host SPI write: address, write bit, pointer, data
// - Serial output stays released during SPI writes
// - Pointer steps per byte only when step set
// - Pointer byte is eight bits, MSB first
// - Host loads pointer by short write before read
// - Falling edge after read bit drives register MSB
// - Two straps captured during reset form address
// - Start and stop change data with clock high
// - Answer only matching address with strap bits
// - I2C write loads pointer then writes registers
// - I2C read returns pointed registers, stepping optional
// - Every byte followed by receiver acknowledge
// - Host writes pointer and stops before reading
// - Host keeps control pins static when idle
// - Alert pin active low, high or open drain
// - Each source maskable; rising, falling or level
// - Reset pin low clears state and mutes
// - Clearing power-down bit starts operation
// - Audio outputs wait for settled PLL when PLL is selected
// - Mute everything 80 ms after power or reset
module ccpr_device
  import ccpr_pkg::*;
#(
  parameter int AW    = 7,
  parameter int RAMP  = RAMP_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  ccpr_if.dev             link,
  input  wire logic [7:0] irq_src,
  input  wire logic       pll_selected,
  input  wire logic       pll_settled,
  output logic            low_power,
  output logic            mute_out,
  output logic            audio_out_en,
  output logic            spi_mode,
  output logic      [1:0] strap_addr
);
  localparam int NREG = 2 ** AW;

  // ----------------------------------------------------------------
  // Pin synchronisation and edges
  // ----------------------------------------------------------------
  logic s_clk, s_pin, s_cs, s_ad1, s_dat;
  logic p_clk, p_cs, p_dat;

  ccpr_sync #(.W(5)) u_sync (
    .clk (ref_clk),
    .rst (rst),
    .d   ({link.control_bit_clock, link.rst_pin_n, link.addr_strap_0_select, link.ad1,
           link.data_line}),
    .q   ({s_clk, s_pin, s_cs, s_ad1, s_dat})
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p_clk <= 1'b0;
      p_cs  <= 1'b0;
      p_dat <= 1'b0;
    end else begin
      p_clk <= s_clk;
      p_cs  <= s_cs;
      p_dat <= s_dat;
    end
  end

  logic            spi_reg;
  logic [1:0]      strap_reg;
  ccpr_dst_t       st_reg;
  logic [3:0]      cnt_reg;
  logic [6:0]      sh_reg;
  logic [7:0]      map_reg;
  logic            ack_pend_reg;
  logic            drive_low_reg;
  logic            dout_reg;
  logic            oe_n_reg;
  logic [7:0]      regs [0:NREG-1];
  logic [7:0]      stat_reg;
  logic [7:0]      src_prev_reg;
  logic [31:0]     ramp_reg;

  wire hw_clr   = ~s_pin;
  wire rise     = s_clk & ~p_clk;
  wire fall     = ~s_clk & p_clk;
  wire cs_fall  = s_pin & p_cs & ~s_cs;
  wire spi_now  = spi_reg | cs_fall;
  wire cs_rise  = spi_reg & s_cs & ~p_cs;
  wire i2c_st   = ~spi_reg & s_clk & p_clk & p_dat & ~s_dat;
  wire i2c_sp   = ~spi_reg & s_clk & p_clk & ~p_dat & s_dat;
  wire in_frame = st_reg != D_IDLE && st_reg != D_IGNORE;

  // ----------------------------------------------------------------
  // Byte decode
  // ----------------------------------------------------------------
  wire [7:0]    byte_in  = {sh_reg, s_dat};
  wire [AW-1:0] idx      = map_reg[AW-1:0];
  wire          step     = map_reg[PTR_STEP_BIT];
  wire [7:0]    map_inc  = {map_reg[7], map_reg[6:0] + 7'h01};
  wire [7:0]    map_nxt  = step ? map_inc : map_reg;
  wire          is_stat  = map_reg[6:0] == REG_IRQ_STAT;
  wire [7:0]    rd_byte  = is_stat ? stat_reg : regs[idx];
  wire          rd_bit   = rd_byte[~cnt_reg[2:0]];
  wire          addr_ok  = spi_reg ? byte_in[7:1] == SPI_CHIP_ADDR
                         : byte_in[7:1] == {I2C_ADDR_HI, strap_reg};
  wire          byte_end = rise && in_frame && cnt_reg == 4'h7;
  wire          ack_bit  = rise && in_frame && cnt_reg == 4'h8;
  wire          wr_en    = byte_end && st_reg == D_WDATA && !is_stat;
  wire          stat_rd  = byte_end && st_reg == D_RDATA && is_stat;

  // ----------------------------------------------------------------
  // Mode selection and strap capture
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      spi_reg   <= 1'b0;
      strap_reg <= 2'h0;
    end else if (hw_clr) begin
      spi_reg   <= 1'b0;
      strap_reg <= {s_ad1, s_cs};
    end else begin
      spi_reg   <= spi_now;
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg       <= D_IDLE;
      cnt_reg      <= 4'h0;
      sh_reg       <= 7'h00;
      map_reg      <= 8'h00;
      ack_pend_reg <= 1'b0;
    end else if (hw_clr) begin
      st_reg       <= D_IDLE;
      cnt_reg      <= 4'h0;
      map_reg      <= 8'h00;
      ack_pend_reg <= 1'b0;
    end else if (i2c_st || cs_fall) begin
      st_reg       <= D_ADDR;
      cnt_reg      <= 4'h0;
      ack_pend_reg <= 1'b0;
    end else if (i2c_sp || cs_rise) begin
      st_reg       <= D_IDLE;
      ack_pend_reg <= 1'b0;
    end else if (ack_bit) begin
      cnt_reg      <= 4'h0;
      ack_pend_reg <= 1'b0;
      // Host refusal ends the read burst
      if (!ack_pend_reg && st_reg == D_RDATA && s_dat) begin
        st_reg <= D_IGNORE;
      end
    end else if (rise && in_frame) begin
      sh_reg  <= byte_in[6:0];
      cnt_reg <= cnt_reg + 4'h1;
      if (byte_end) begin
        cnt_reg      <= spi_reg ? 4'h0 : 4'h8;
        ack_pend_reg <= !spi_reg && (st_reg != D_RDATA)
                        && (st_reg != D_ADDR || addr_ok);
        unique case (st_reg)
          D_ADDR: begin
            if (!addr_ok) begin
              st_reg <= D_IGNORE;
            end else begin
              st_reg <= byte_in[0] ? D_RDATA : D_PTR;
            end
          end
          D_PTR: begin
            map_reg <= byte_in;
            st_reg  <= D_WDATA;
          end
          D_WDATA: map_reg <= map_nxt;
          D_RDATA: map_reg <= map_nxt;
          default: st_reg <= st_reg;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register array
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NREG; i++) begin
        regs[i] <= 8'h00;
      end
      regs[REG_PWR[AW-1:0]] <= PWR_RST;
    end else if (hw_clr) begin
      for (int i = 0; i < NREG; i++) begin
        regs[i] <= 8'h00;
      end
      regs[REG_PWR[AW-1:0]] <= PWR_RST;
    end else if (wr_en) begin
      regs[idx] <= byte_in;
    end
  end

  // ----------------------------------------------------------------
  // Data pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drive_low_reg <= 1'b0;
      dout_reg      <= 1'b0;
      oe_n_reg      <= 1'b1;
    end else begin
      if (hw_clr || spi_reg || i2c_st || i2c_sp) begin
        drive_low_reg <= 1'b0;
      end else if (fall) begin
        drive_low_reg <= (cnt_reg == 4'h8 && ack_pend_reg)
          || (st_reg == D_RDATA && !cnt_reg[3] && !ack_pend_reg
              && !rd_bit);
      end
      if (fall && st_reg == D_RDATA) begin
        dout_reg <= rd_bit;
      end
      // Released on select high and outside reads
      if (!spi_reg || s_cs || st_reg != D_RDATA) begin
        oe_n_reg <= 1'b1;
      end else if (fall) begin
        oe_n_reg <= 1'b0;
      end
    end
  end

  assign link.dev_sda_oe_n = ~drive_low_reg;
  assign link.control_serial_out_o      = dout_reg;
  assign link.control_serial_out_oe_n   = oe_n_reg;

  // ----------------------------------------------------------------
  // Interrupt sources and alert pin
  // ----------------------------------------------------------------
  function automatic logic [7:0] trig_ev(input logic [7:0] cur,
      input logic [7:0] prv, input logic [7:0] hi, input logic [7:0] lo);
    // 00 level, 01 rising, 10 falling, 11 level
    trig_ev = (~(hi ^ lo) & cur) | (~hi & lo & cur & ~prv)
            | (hi & ~lo & ~cur & prv);
  endfunction : trig_ev

  wire [7:0] irq_ev = trig_ev(irq_src, src_prev_reg,
                              regs[REG_TRIG_HI[AW-1:0]],
                              regs[REG_TRIG_LO[AW-1:0]]);
  wire       alert_act = |(stat_reg & regs[REG_IRQ_MASK[AW-1:0]]);
  wire [1:0] alert_cfg = regs[REG_ALERT_CFG[AW-1:0]][1:0];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      src_prev_reg <= 8'h00;
      stat_reg     <= 8'h00;
      link.alert_o    <= 1'b1;
      link.alert_oe_n <= 1'b0;
    end else begin
      src_prev_reg <= irq_src;
      // Read clears, a fresh event in the same cycle survives
      stat_reg <= hw_clr ? 8'h00
                : ((stat_rd ? 8'h00 : stat_reg) | irq_ev);
      unique case (alert_cfg)
        ALERT_HIGH: begin
          link.alert_o    <= alert_act;
          link.alert_oe_n <= 1'b0;
        end
        ALERT_OD: begin
          link.alert_o    <= 1'b0;
          link.alert_oe_n <= ~alert_act;
        end
        default: begin
          link.alert_o    <= ~alert_act;
          link.alert_oe_n <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power, reference ramp and mute
  // ----------------------------------------------------------------
  wire power_down_bit = regs[REG_PWR[AW-1:0]][PDN_BIT];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ramp_reg     <= 32'(RAMP);
      low_power    <= 1'b1;
      mute_out     <= 1'b1;
      audio_out_en <= 1'b0;
    end else begin
      if (hw_clr) begin
        ramp_reg <= 32'(RAMP);
      end else if (ramp_reg != 32'h0) begin
        ramp_reg <= ramp_reg - 32'h1;
      end
      low_power    <= hw_clr | power_down_bit;
      mute_out     <= hw_clr | power_down_bit | (ramp_reg != 32'h0);
      audio_out_en <= !hw_clr && !power_down_bit && ramp_reg == 32'h0
                      && (!pll_selected || pll_settled);
    end
  end

  assign spi_mode   = spi_reg;
  assign strap_addr = strap_reg;
endmodule : ccpr_device

/* File: rtl/ccpr_host.sv */
`timescale 1ns/1ps
module ccpr_host
  import ccpr_pkg::*;
#(
  parameter int QTR = HOST_QTR_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  ccpr_if.host             link
);
  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic       ack_reg, rd_reg, po_reg, nack_reg;
  logic [7:0] ptr_reg, wdata_reg, rdata_reg;
  logic [3:0] pin_reg;
  ccpr_hst_t  st_reg;

  wire req  = avs_read | avs_write;
  wire busy = st_reg != H_IDLE;
  wire wr   = avs_write & ack_reg;
  wire go   = wr && avs_address == HA_CTRL && avs_writedata[CTRL_GO];
  wire [31:0] rmux =
      avs_address == HA_CTRL  ? {29'h0, po_reg, rd_reg, busy} :
      avs_address == HA_PTR   ? {24'h0, ptr_reg} :
      avs_address == HA_WDATA ? {24'h0, wdata_reg} :
      avs_address == HA_RDATA ? {24'h0, rdata_reg} :
      avs_address == HA_STAT  ? {30'h0, nack_reg, busy} :
      avs_address == HA_PIN   ? {28'h0, pin_reg} : 32'h0;

  assign avs_waitrequest = req & ~ack_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h0;
      ptr_reg      <= 8'h00;
      wdata_reg    <= 8'h00;
      pin_reg      <= 4'h0;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (avs_read && !ack_reg) begin
        avs_readdata <= rmux;
      end
      if (wr && avs_address == HA_PTR) begin
        ptr_reg <= avs_writedata[7:0];
      end
      if (wr && avs_address == HA_WDATA) begin
        wdata_reg <= avs_writedata[7:0];
      end
      if (wr && avs_address == HA_PIN) begin
        pin_reg <= avs_writedata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Link sequencer
  // ----------------------------------------------------------------
  logic [1:0] s_in;
  logic [7:0] qcnt_reg;
  logic [1:0] ph_reg, byte_reg;
  logic [3:0] bit_reg;
  logic       frm_reg, scl_reg, dout_reg, cs_reg;
  logic [6:0] rx_reg;

  ccpr_sync #(.W(2)) u_sync (
    .clk (ref_clk),
    .rst (rst),
    .d   ({link.data_line, link.control_serial_out_line}),
    .q   (s_in)
  );

  function automatic logic [7:0] tx_byte(input logic i2c,
      input logic frm, input logic [1:0] n, input logic [1:0] strap,
      input logic [7:0] p, input logic [7:0] w);
    logic [6:0] a;
    a = i2c ? {I2C_ADDR_HI, strap} : SPI_CHIP_ADDR;
    tx_byte = (n == 2'h0) ? {a, frm} : (n == 2'h1) ? p : w;
  endfunction : tx_byte

  wire       i2c   = pin_reg[PIN_I2C];
  wire       tick  = qcnt_reg == 8'(QTR - 1);
  wire       rx    = frm_reg && byte_reg == 2'h1;
  wire [1:0] last  = (frm_reg || rd_reg || po_reg) ? 2'h1 : 2'h2;
  wire [3:0] nbit  = i2c ? 4'h8 : 4'h7;
  wire       in_b  = i2c ? s_in[1] : s_in[0];
  wire [7:0] txb   = tx_byte(i2c, frm_reg, byte_reg,
                             pin_reg[PIN_STRAP1:PIN_STRAP0],
                             ptr_reg, wdata_reg);
  wire       tx_b  = txb[~bit_reg[2:0]];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      qcnt_reg <= 8'h00;
      ph_reg   <= 2'h0;
    end else begin
      qcnt_reg <= (tick || !busy) ? 8'h00 : qcnt_reg + 8'h01;
      ph_reg   <= !busy ? 2'h0 : tick ? ph_reg + 2'h1 : ph_reg;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= H_IDLE;
      {rd_reg, po_reg, nack_reg, frm_reg} <= 4'h0;
      {scl_reg, dout_reg, cs_reg} <= 3'h7;
      bit_reg <= 4'h0;
      byte_reg <= 2'h0;
      rx_reg <= 7'h00;
      rdata_reg <= 8'h00;
    end else if (st_reg == H_IDLE) begin
      if (go) begin
        st_reg   <= H_START;
        rd_reg   <= avs_writedata[CTRL_RD];
        po_reg   <= avs_writedata[CTRL_PO];
        nack_reg <= 1'b0;
        frm_reg  <= 1'b0;
      end
    end else if (tick) begin
      unique case (st_reg)
        H_START: begin
          if (ph_reg == 2'h0) begin
            dout_reg <= 1'b0;
            cs_reg   <= 1'b0;
          end else if (ph_reg == 2'h1) begin
            scl_reg  <= 1'b0;
          end else if (ph_reg == 2'h3) begin
            st_reg   <= H_BIT;
            bit_reg  <= 4'h0;
            byte_reg <= 2'h0;
          end
        end
        H_BIT: begin
          if (ph_reg == 2'h0) begin
            scl_reg  <= 1'b0;
          end else if (ph_reg == 2'h1) begin
            dout_reg <= (!bit_reg[3] && !rx) ? tx_b : 1'b1;
          end else if (ph_reg == 2'h2) begin
            scl_reg  <= 1'b1;
          end else begin
            rx_reg <= {rx_reg[5:0], in_b};
            if (rx && bit_reg == 4'h7) begin
              rdata_reg <= {rx_reg, in_b};
            end
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == 4'h8 && !rx && in_b) begin
              nack_reg <= 1'b1;
              st_reg   <= H_STOP;
            end else if (bit_reg == nbit) begin
              bit_reg  <= 4'h0;
              byte_reg <= byte_reg + 2'h1;
              if (byte_reg == last) begin
                st_reg <= H_STOP;
              end
            end
          end
        end
        H_STOP: begin
          if (ph_reg == 2'h0) begin
            scl_reg  <= 1'b0;
          end else if (ph_reg == 2'h1) begin
            dout_reg <= 1'b0;
          end else if (ph_reg == 2'h2) begin
            scl_reg  <= 1'b1;
          end else begin
            dout_reg <= 1'b1;
            cs_reg   <= 1'b1;
            st_reg   <= (rd_reg && !frm_reg && !nack_reg)
                        ? H_GAP : H_IDLE;
          end
        end
        H_GAP: begin
          if (ph_reg == 2'h3) begin
            frm_reg <= 1'b1;
            st_reg  <= H_START;
          end
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end

  assign link.control_bit_clock          = scl_reg;
  assign link.rst_pin_n     = pin_reg[PIN_RST_N];
  assign link.addr_strap_0_select        = i2c ? pin_reg[PIN_STRAP0] : cs_reg;
  assign link.ad1           = pin_reg[PIN_STRAP1];
  assign link.host_din_o    = dout_reg;
  assign link.host_din_oe_n = i2c ? dout_reg : 1'b0;
endmodule : ccpr_host

/* File: tb/ccpr_monitor.sv */
`timescale 1ns/1ps
module ccpr_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic control_bit_clock,
  input wire logic rst_pin_n,
  input wire logic addr_strap_0_select,
  input wire logic dev_sda_oe_n,
  input wire logic control_serial_out_o,
  input wire logic control_serial_out_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence out_on;
    $fell(control_serial_out_oe_n);
  endsequence
  chk_sel_release: assert property (
    $rose(addr_strap_0_select) |-> ##[0:6] control_serial_out_oe_n) else $error("out kept");
  chk_idle_hiz: assert property (
    addr_strap_0_select [*8] |-> control_serial_out_oe_n) else $error("out driven idle");
  chk_reset_quiet: assert property (
    (!rst_pin_n) [*4] |-> control_serial_out_oe_n && dev_sda_oe_n)
    else $error("drive in reset");
  chk_out_edge: assert property (
    out_on |-> !addr_strap_0_select && !control_bit_clock) else $error("bad out enable");
  chk_out_falling: assert property (
    !control_serial_out_oe_n && $changed(control_serial_out_o) |-> !control_bit_clock)
    else $error("out moved clock high");
  chk_sda_clk_low: assert property (
    rst_pin_n && $changed(dev_sda_oe_n) |-> !control_bit_clock)
    else $error("data moved clock high");
  chk_ack_bound: assert property (
    $fell(dev_sda_oe_n) |-> ##[1:200] dev_sda_oe_n)
    else $error("data held low");
  chk_mode_excl: assert property (
    !control_serial_out_oe_n |-> dev_sda_oe_n) else $error("both modes drive");
endmodule : ccpr_monitor

/* File: tb/ccpr_tb_top.sv */
`timescale 1ns/1ps
module ccpr_tb_top;
  import ccpr_pkg::*;
  logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [2:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        low_power, mute_out, audio_out_en, spi_mode;
  logic        pll_sel, pll_ok;
  logic [7:0]  irq;
  logic [1:0]  strap_addr;
  int          n_fail = 0, n_checks = 0, cyc = 0;
  ccpr_if link ();
  ccpr_device #(.RAMP(50)) ccpr_device_i (.ref_clk(ref_clk), .rst(rst),
    .link(link), .irq_src(irq), .pll_selected(pll_sel), .pll_settled(pll_ok),
    .low_power(low_power), .mute_out(mute_out), .audio_out_en(audio_out_en),
    .spi_mode(spi_mode), .strap_addr(strap_addr));
  ccpr_host ccpr_host_i (.ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link));
  ccpr_monitor ccpr_monitor_i (.ref_clk(ref_clk), .rst(rst),
    .control_bit_clock(link.control_bit_clock), .rst_pin_n(link.rst_pin_n), .addr_strap_0_select(link.addr_strap_0_select),
    .dev_sda_oe_n(link.dev_sda_oe_n), .control_serial_out_o(link.control_serial_out_o),
    .control_serial_out_oe_n(link.control_serial_out_oe_n));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic results();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // Hang guard, well above the longest expected run
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Request holds until the edge that sees waitrequest low
  task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    // One idle edge so the next call never reasserts in this step
    @(posedge ref_clk);
  endtask : av
  task automatic xfer(input logic [7:0] c, input logic [7:0] p,
                      input logic [7:0] w);
    int i;
    av(1'b1, HA_PTR, {24'h0, p});
    av(1'b1, HA_WDATA, {24'h0, w});
    av(1'b1, HA_CTRL, {24'h0, c});
    for (i = 0; i < 3000; i++) begin
      av(1'b0, HA_STAT, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    chk("idle", 32'h0, {31'h0, rd[0]});
  endtask : xfer
  task automatic pin(input logic [3:0] v);
    av(1'b1, HA_PIN, {28'h0, v});
    repeat (8) @(posedge ref_clk);
  endtask : pin
  task automatic rdreg(input logic [7:0] p);
    xfer(8'h03, p, 8'h00);
    av(1'b0, HA_RDATA, 32'h0);
  endtask : rdreg
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {pll_sel, pll_ok, irq} = {1'b0, 1'b1, 8'h00};
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    pin(4'hA);
    pin(4'hB);
    chk("strap", 32'h2, {30'h0, strap_addr});
    chk("mute", 32'h1, {31'h0, mute_out});
    chk("lowpwr", 32'h1, {31'h0, low_power});
    xfer(8'h01, {1'b0, REG_PWR}, 8'h80);
    chk("powerup", 32'h0, {31'h0, low_power});
    chk("unmute", 32'h0, {31'h0, mute_out});
    chk("audio on", 32'h1, {31'h0, audio_out_en});
    pll_sel <= 1'b1;
    pll_ok  <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("pll wait", 32'h0, {31'h0, audio_out_en});
    pll_ok <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("pll ok", 32'h1, {31'h0, audio_out_en});
    $display("power tests done");
    chk("i2c mode", 32'h0, {31'h0, spi_mode});
    xfer(8'h01, 8'h90, 8'hA5);
    rdreg(8'h10);
    chk("i2c rd", 32'hA5, {24'h0, rd[7:0]});
    pin(4'h3);
    xfer(8'h01, 8'h10, 8'h5A);
    chk("nack", 32'h1, {31'h0, rd[1]});
    pin(4'hB);
    rdreg(8'h10);
    chk("no write", 32'hA5, {24'h0, rd[7:0]});
    $display("i2c tests done");
    pin(4'hA);
    pin(4'hB);
    rdreg(8'h10);
    chk("cleared", 32'h0, {24'h0, rd[7:0]});
    $display("reset test done");
    xfer(8'h01, 8'h21, 8'h01);
    chk("alert idle", 32'h1, {31'h0, link.alert_line});
    irq <= 8'h03;
    repeat (4) @(posedge ref_clk);
    chk("alert low", 32'h0, {31'h0, link.alert_line});
    irq <= 8'h00;
    xfer(8'h01, 8'h1F, 8'h01);
    chk("alert high", 32'h1, {31'h0, link.alert_line});
    rdreg(8'h20);
    chk("irq stat", 32'h03, {24'h0, rd[7:0]});
    chk("alert clear", 32'h0, {31'h0, link.alert_line});
    irq <= 8'h02;
    repeat (4) @(posedge ref_clk);
    chk("alert masked", 32'h0, {31'h0, link.alert_line});
    xfer(8'h01, 8'h1F, 8'h02);
    chk("alert od off", 32'h1, {31'h0, link.alert_line});
    irq <= 8'h01;
    repeat (4) @(posedge ref_clk);
    chk("alert od on", 32'h0, {31'h0, link.alert_line});
    irq <= 8'h00;
    $display("alert tests done");
    pin(4'h0);
    pin(4'h1);
    xfer(8'h01, 8'h11, 8'h3C);
    chk("spi mode", 32'h1, {31'h0, spi_mode});
    rdreg(8'h11);
    chk("spi rd", 32'h3C, {24'h0, rd[7:0]});
    $display("spi tests done");
    results();
  end
endmodule : ccpr_tb_top
